// file: rtl/tis_event_if.sv
// Event and qualified-set signals between the status core and the qualifier
`timescale 1ns/10ps
interface tis_event_if;
   import tis_pkg::*;
   logic [1:0]   timeout_evt;
   logic [1:0]   match_evt;
   logic [1:0]   cap_evt;
   logic [1:0]   cap_match_evt;
   logic [1:0]   dma_evt;
   logic [1:0]   match_ie;
   tis_mode_type mode_a;
   tis_mode_type mode_b;
   logic [31:0]  set_vec;

   modport core (output timeout_evt, match_evt, cap_evt, cap_match_evt, dma_evt,
                 output match_ie, mode_a, mode_b, input set_vec);
   modport qual (input timeout_evt, match_evt, cap_evt, cap_match_evt, dma_evt,
                 input match_ie, mode_a, mode_b, output set_vec);
endinterface

// file: rtl/tis_event_qualify.sv
// Qualifies subtimer event pulses by mode into raw-flag set requests
`timescale 1ns/10ps
module tis_event_qualify
   import tis_pkg::*;
(
   tis_event_if.qual ev
);

   // One subtimer's set bits; reserved positions stay zero
   function automatic logic [7:0] qualify(input tis_mode_type mode,
                                          input int match_pos,
                                          input logic timeout,
                                          input logic match,
                                          input logic match_ie,
                                          input logic cap,
                                          input logic cap_match,
                                          input logic dma);
      logic [7:0] bits;
      logic       counting;
      logic       capturing;
      bits = 8'h00;
      counting = (mode == TIS_MODE_ONESHOT) || (mode == TIS_MODE_PERIODIC);
      capturing = (mode == TIS_MODE_CAPTURE);
      bits[TIS_TIMEOUT_POS] = timeout & counting;
      bits[match_pos] = match & match_ie & counting;
      bits[TIS_CAP_EVENT_POS] = cap & capturing;
      bits[TIS_CAP_MATCH_POS] = cap_match & capturing;
      bits[TIS_DMA_POS] = dma;
      return bits;
   endfunction

   // Same qualification for both subtimers, B in the upper byte
   always_comb begin
      ev.set_vec = {16'h0000,
                    qualify(ev.mode_b, TIS_MATCH_B_POS, ev.timeout_evt[1], ev.match_evt[1],
                            ev.match_ie[1], ev.cap_evt[1], ev.cap_match_evt[1], ev.dma_evt[1]),
                    qualify(ev.mode_a, TIS_MATCH_POS, ev.timeout_evt[0], ev.match_evt[0],
                            ev.match_ie[0], ev.cap_evt[0], ev.cap_match_evt[0], ev.dma_evt[0])};
   end

endmodule

// file: rtl/tis_pkg.sv
// Constants and types for the timer interrupt status block
// Operation
// - Time-out raw flag (bit 0 A, bit 8 B) sets at count limit, one-shot/periodic.
// - Subtimer A DMA-done raw flag at bit 5 sets once its transfer completes.
// - Subtimer A match raw flag bit 4 needs match enable and match, one-shot/periodic.
// - Subtimer A capture-event raw flag bit 2 sets on capture in edge-time mode.
// - Subtimer A capture-match raw flag bit 1 sets on match in edge-time mode.
// - Raw flags stay set until software writes one to the clear register.
// - Masked bit reads one only for an occurred and enabled event.
// - Writing one to a clear bit clears masked and raw bits together.
// - Masked layout: B DMA 13, match 11, cap event 10, cap match 9, time-out 8; A DMA 5.
// - Subtimer B match masked flag sets only unmasked; cleared by its clear bit.
// - Subtimer B capture masked flags at 10 and 9 only for unmasked events.
// - A mask bit of one shows its event masked; zero suppresses it.
package tis_pkg;

   // Register byte offsets
   localparam logic [7:0]  TIS_MASK_OFFSET   = 8'h18;
   localparam logic [7:0]  TIS_RAW_OFFSET    = 8'h1c;
   localparam logic [7:0]  TIS_MASKED_OFFSET = 8'h20;
   localparam logic [7:0]  TIS_CLEAR_OFFSET  = 8'h24;

   // Field positions inside one subtimer byte
   localparam int          TIS_TIMEOUT_POS   = 0;
   localparam int          TIS_CAP_MATCH_POS = 1;
   localparam int          TIS_CAP_EVENT_POS = 2;
   localparam int          TIS_MATCH_POS     = 4;
   // Subtimer B match sits at bit 11, not at the A position plus eight
   localparam int          TIS_MATCH_B_POS   = 3;
   localparam int          TIS_DMA_POS       = 5;
   localparam int          TIS_SUB_B_SHIFT   = 8;

   // Reset values and implemented bits
   localparam logic [31:0] TIS_STATUS_RESET  = 32'h0000_0000;
   localparam logic [31:0] TIS_MASK_RESET    = 32'h0000_0000;
   localparam logic [31:0] TIS_IMPL_BITS     = 32'h0000_2f37;

   // Subtimer counting mode as seen by this block
   typedef enum logic [1:0] {
      TIS_MODE_OFF      = 2'h0,
      TIS_MODE_ONESHOT  = 2'h1,
      TIS_MODE_PERIODIC = 2'h3,
      TIS_MODE_CAPTURE  = 2'h2
   } tis_mode_type;

   // Bus slave states
   typedef enum logic {
      TIS_BUS_IDLE = 1'b0,
      TIS_BUS_ACK  = 1'b1
   } tis_bus_type;

endpackage

// file: rtl/tis_timer_irq.sv
// Timer interrupt status core: raw, mask, masked and clear registers on Wishbone
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/10ps
module tis_timer_irq
   import tis_pkg::*;
(
   input  wire logic         sys_clk_in,
   input  wire logic         reset_in,
   input  wire logic         wb_cyc_in,
   input  wire logic         wb_stb_in,
   input  wire logic         wb_we_in,
   input  wire logic [7:0]   wb_adr_in,
   input  wire logic [3:0]   wb_sel_in,
   input  wire logic [31:0]  wb_dat_in,
   output logic [31:0]       wb_dat_out,
   output logic              wb_ack_out,
   input  wire logic [1:0]   timeout_evt_in,
   input  wire logic [1:0]   match_evt_in,
   input  wire logic [1:0]   match_irq_enable_in,
   input  wire logic [1:0]   capture_evt_in,
   input  wire logic [1:0]   capture_match_evt_in,
   input  wire logic [1:0]   dma_done_in,
   input  wire tis_mode_type mode_a_in,
   input  wire tis_mode_type mode_b_in,
   output logic              irq_out
);

   // Word address compare, shared by read and write decode
   function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] offset);
      return adr[7:2] == offset[7:2];
   endfunction

   tis_event_if   ev ();
   tis_bus_type   state;
   tis_bus_type   next_state;
   logic [31:0]   raw;
   logic [31:0]   next_raw;
   logic [31:0]   mask;
   logic [31:0]   next_mask;
   logic [31:0]   next_rdata;
   logic          next_irq;
   logic [31:0]   masked;
   logic [31:0]   lane_mask;
   logic [31:0]   clear_vec;
   logic          req;
   logic          wr_now;
   logic          rd_start;

   // Event pins into the qualifier
   assign ev.timeout_evt   = timeout_evt_in;
   assign ev.match_evt     = match_evt_in;
   assign ev.cap_evt       = capture_evt_in;
   assign ev.cap_match_evt = capture_match_evt_in;
   assign ev.dma_evt       = dma_done_in;
   assign ev.match_ie      = match_irq_enable_in;
   assign ev.mode_a        = mode_a_in;
   assign ev.mode_b        = mode_b_in;

   tis_event_qualify u_qualify (
      .ev (ev.qual)
   );

   // Masked view is always derived, so it can never disagree with raw
   assign masked = raw & mask;

   // Bus request decode
   assign req       = wb_cyc_in & wb_stb_in;
   assign wr_now    = (state == TIS_BUS_ACK) & req & wb_we_in;
   assign rd_start  = (state == TIS_BUS_IDLE) & req & ~wb_we_in;
   assign lane_mask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
                       {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
   assign wb_ack_out = (state == TIS_BUS_ACK);

   // Clear strobes; zero bits clear nothing
   always_comb begin
      clear_vec = 32'h0000_0000;
      if (wr_now && reg_hit(wb_adr_in, TIS_CLEAR_OFFSET)) begin
         clear_vec = wb_dat_in & lane_mask & TIS_IMPL_BITS;
      end
   end

   // Bus state: one wait cycle, then ack for exactly one cycle
   always_comb begin
      next_state = state;
      case (state)
         TIS_BUS_IDLE: begin
            if (req) begin
               next_state = TIS_BUS_ACK;
            end
         end
         TIS_BUS_ACK: begin
            next_state = TIS_BUS_IDLE;
         end
         default: begin
            next_state = TIS_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         state <= TIS_BUS_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Status and mask next values; a set in the clear cycle wins
   always_comb begin
      next_raw = ((raw & ~clear_vec) | ev.set_vec) & TIS_IMPL_BITS;
      next_mask = mask;
      if (wr_now && reg_hit(wb_adr_in, TIS_MASK_OFFSET)) begin
         next_mask = ((mask & ~lane_mask) | (wb_dat_in & lane_mask)) & TIS_IMPL_BITS;
      end
      // Registered so the line never glitches on decode
      next_irq = |(next_raw & next_mask);
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         raw  <= TIS_STATUS_RESET;
         mask <= TIS_MASK_RESET;
         irq_out <= 1'b0;
      end else begin
         raw  <= next_raw;
         mask <= next_mask;
         irq_out <= next_irq;
      end
   end

   // Read mux, sampled at request start; status registers are read-only
   always_comb begin
      next_rdata = wb_dat_out;
      if (rd_start) begin
         if (reg_hit(wb_adr_in, TIS_RAW_OFFSET)) begin
            next_rdata = raw;
         end else if (reg_hit(wb_adr_in, TIS_MASKED_OFFSET)) begin
            next_rdata = masked;
         end else if (reg_hit(wb_adr_in, TIS_MASK_OFFSET)) begin
            next_rdata = mask;
         end else begin
            next_rdata = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         wb_dat_out <= 32'h0000_0000;
      end else begin
         wb_dat_out <= next_rdata;
      end
   end

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);

   a_set_captured: assert property (
      (ev.set_vec != 32'h0000_0000)
      |=> ((raw & $past(ev.set_vec)) == $past(ev.set_vec)))
      else $error("event did not set its raw flag");

   a_clear_acts: assert property (
      (clear_vec != 32'h0000_0000)
      |=> ((raw & $past(clear_vec) & ~$past(ev.set_vec)) == 32'h0000_0000))
      else $error("clear write left a flag set");

   a_raw_sticky: assert property (
      (clear_vec == 32'h0000_0000) |=> ((raw & $past(raw)) == $past(raw)))
      else $error("raw flag dropped without a clear");

   a_timeout_a: assert property (
      (timeout_evt_in[0] && (mode_a_in == TIS_MODE_PERIODIC)) |=> raw[0])
      else $error("subtimer A time-out not flagged");

   a_match_gate: assert property (
      (!match_irq_enable_in[0] && !raw[4]) |=> !raw[4])
      else $error("match flag set with match enable off");

   a_dma_a: assert property (
      dma_done_in[0] |=> raw[5])
      else $error("subtimer A DMA done not flagged");

   a_cap_b_mode: assert property (
      (capture_evt_in[1] && (mode_b_in == TIS_MODE_CAPTURE)) |=> raw[10])
      else $error("subtimer B capture event not flagged");

   a_cap_a_gate: assert property (
      ((mode_a_in != TIS_MODE_CAPTURE) && !raw[2]) |=> !raw[2])
      else $error("capture flag outside edge-time mode");

   a_irq_level: assert property (
      ##1 (irq_out == |(raw & mask)))
      else $error("interrupt output disagrees with masked status");

   a_masked_read: assert property (
      (rd_start && reg_hit(wb_adr_in, TIS_MASKED_OFFSET))
      |=> (wb_ack_out && (wb_dat_out == $past(masked))))
      else $error("masked read returned wrong data");

   a_ack_single: assert property (
      (req && !wb_ack_out) |=> wb_ack_out ##1 !wb_ack_out)
      else $error("ack not a single cycle after one wait");

   a_reserved_zero: assert property (
      ((raw & ~TIS_IMPL_BITS) == 32'h0000_0000) && ((mask & ~TIS_IMPL_BITS) == 32'h0000_0000))
      else $error("reserved bit became set");

   a_mask_write: assert property (
      (wr_now && reg_hit(wb_adr_in, TIS_MASK_OFFSET) && (wb_sel_in == 4'hf))
      |=> (mask == ($past(wb_dat_in) & TIS_IMPL_BITS)))
      else $error("mask write not stored");

   a_match_a_set: assert property (
      (match_evt_in[0] && match_irq_enable_in[0] && (mode_a_in == TIS_MODE_PERIODIC))
      |=> raw[4])
      else $error("subtimer A match not flagged");

   a_match_mode_gate: assert property (
      ((mode_a_in == TIS_MODE_CAPTURE) && !raw[4])
      |=> !raw[4])
      else $error("subtimer A match flagged in capture mode");

   a_match_b_set: assert property (
      (match_evt_in[1] && match_irq_enable_in[1] && (mode_b_in == TIS_MODE_ONESHOT))
      |=> raw[11])
      else $error("subtimer B match not flagged at its bit");

   a_match_b_gate: assert property (
      (!match_irq_enable_in[1] && !raw[11])
      |=> !raw[11])
      else $error("subtimer B match set with enable off");

   a_timeout_b: assert property (
      (timeout_evt_in[1] && (mode_b_in == TIS_MODE_ONESHOT))
      |=> raw[8])
      else $error("subtimer B time-out not flagged");

   a_timeout_gate: assert property (
      (((mode_a_in == TIS_MODE_CAPTURE) || (mode_a_in == TIS_MODE_OFF)) && !raw[0])
      |=> !raw[0])
      else $error("time-out flagged outside counting modes");

   a_cap_event_a: assert property (
      (capture_evt_in[0] && (mode_a_in == TIS_MODE_CAPTURE))
      |=> raw[2])
      else $error("subtimer A capture event not flagged");

   a_cap_match_a: assert property (
      (capture_match_evt_in[0] && (mode_a_in == TIS_MODE_CAPTURE))
      |=> raw[1])
      else $error("subtimer A capture match not flagged");

   a_cap_match_gate: assert property (
      ((mode_a_in != TIS_MODE_CAPTURE) && !raw[1])
      |=> !raw[1])
      else $error("capture match outside edge-time mode");

   a_cap_b_gate: assert property (
      ((mode_b_in != TIS_MODE_CAPTURE) && !raw[10] && !raw[9])
      |=> (!raw[10] && !raw[9]))
      else $error("subtimer B capture flag outside edge-time mode");

   a_cap_match_b: assert property (
      (capture_match_evt_in[1] && (mode_b_in == TIS_MODE_CAPTURE))
      |=> raw[9])
      else $error("subtimer B capture match not flagged");

   a_dma_b: assert property (
      dma_done_in[1]
      |=> raw[13])
      else $error("subtimer B DMA done not flagged");

   a_dma_a_idle: assert property (
      (!dma_done_in[0] && !raw[5])
      |=> !raw[5])
      else $error("DMA done flag set without a transfer end");

   a_masked_clear_b: assert property (
      (clear_vec[13] && !ev.set_vec[13])
      |=> !masked[13])
      else $error("masked DMA done survived its clear");

   a_zero_keeps: assert property (
      (wr_now && reg_hit(wb_adr_in, TIS_CLEAR_OFFSET))
      |=> ((raw & $past(raw) & ~$past(wb_dat_in)) == ($past(raw) & ~$past(wb_dat_in))))
      else $error("zero bit of a clear dropped a flag");

   a_status_ro: assert property (
      (wr_now && (reg_hit(wb_adr_in, TIS_RAW_OFFSET) ||
                  reg_hit(wb_adr_in, TIS_MASKED_OFFSET)))
      |=> (raw == ($past(raw) | $past(ev.set_vec))))
      else $error("status register took a write");

   a_mask_keep: assert property (
      !(wr_now && reg_hit(wb_adr_in, TIS_MASK_OFFSET))
      |=> $stable(mask))
      else $error("mask changed without a mask write");

   a_raw_read: assert property (
      (rd_start && reg_hit(wb_adr_in, TIS_RAW_OFFSET))
      |=> (wb_dat_out == $past(raw)))
      else $error("raw read returned wrong data");

   a_clear_read_zero: assert property (
      (rd_start && reg_hit(wb_adr_in, TIS_CLEAR_OFFSET))
      |=> (wb_dat_out == 32'h0000_0000))
      else $error("clear register read not zero");

   // Read data must hold between reads, the master may sample late
   a_rdata_hold: assert property (
      !rd_start
      |=> $stable(wb_dat_out))
      else $error("read data moved without a read");

   a_ack_needs_req: assert property (
      (!req && !wb_ack_out)
      |=> !wb_ack_out)
      else $error("ack without a request");

endmodule

// file: sim/test_tis_timer_irq.sv
// Self-checking bench for the timer interrupt status block over Wishbone
`timescale 1ns/10ps
`define CHK(name, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
   $display("[FAIL] %s expected %h seen %h", name, exp, got); end end
module test_tis_timer_irq
   import tis_pkg::*;
;
   logic         sys_clk_in = 1'b0;
   logic         reset_in   = 1'b1;
   logic         cyc        = 1'b0;
   logic         stb        = 1'b0;
   logic         we         = 1'b0;
   logic [7:0]   adr        = 8'h00;
   logic [3:0]   sel        = 4'h0;
   logic [31:0]  wdat       = 32'h0000_0000;
   logic [31:0]  dat_out;
   logic         ack;
   logic         irq;
   logic [1:0]   to_e = 2'h0, m_e = 2'h0, ie = 2'h0, ce = 2'h0, cm = 2'h0, dma = 2'h0;
   tis_mode_type mode_a = TIS_MODE_OFF;
   tis_mode_type mode_b = TIS_MODE_OFF;
   int           n_errors   = 0;
   int           num_checks = 0;
   int           cycles     = 0;

   tis_timer_irq DUT (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .wb_cyc_in(cyc),
      .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
      .wb_dat_out(dat_out), .wb_ack_out(ack), .timeout_evt_in(to_e), .match_evt_in(m_e),
      .match_irq_enable_in(ie), .capture_evt_in(ce), .capture_match_evt_in(cm),
      .dma_done_in(dma), .mode_a_in(mode_a), .mode_b_in(mode_b), .irq_out(irq));

   // 50 MHz clock
   always #10 sys_clk_in = ~sys_clk_in;

   // Closing report, the only exit of the run
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Hang guard; the whole sequence needs well under a thousand cycles
   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         give_verdict();
      end
   end

   // Classic single cycle; waits for ack without assuming a latency
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge sys_clk_in);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= s;
      do begin
         @(posedge sys_clk_in);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = dat_out;
      if (n >= 50) n_errors++;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask

   // One-cycle event pulse with its mode and match enable as level qualifiers
   task automatic pulse(input int k, input int s, input tis_mode_type md, input logic [1:0] en);
      logic [1:0] b;
      b = 2'b01 << s;
      @(posedge sys_clk_in);
      mode_a <= md;
      mode_b <= md;
      ie     <= en;
      case (k)
         0: to_e <= b;
         1: m_e <= b;
         2: ce <= b;
         3: cm <= b;
         default: dma <= b;
      endcase
      @(posedge sys_clk_in);
      to_e <= 2'h0;
      m_e  <= 2'h0;
      ce   <= 2'h0;
      cm   <= 2'h0;
      dma  <= 2'h0;
   endtask

   // Main sequence
   initial begin
      logic [31:0]  q;
      logic [31:0]  e;
      tis_mode_type good;
      tis_mode_type bad;
      int           pos [5];
      pos = '{TIS_TIMEOUT_POS, TIS_MATCH_POS, TIS_CAP_EVENT_POS, TIS_CAP_MATCH_POS, TIS_DMA_POS};
      repeat (12) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      bus(1'b0, TIS_RAW_OFFSET, 32'h0, 4'hf, q);
      `CHK("raw reset", TIS_STATUS_RESET, q)
      bus(1'b0, TIS_MASKED_OFFSET, 32'h0, 4'hf, q);
      `CHK("masked reset", TIS_STATUS_RESET, q)
      bus(1'b1, TIS_MASK_OFFSET, 32'hffff_ffff, 4'hf, q);
      // Every event kind on both subtimers, wrong qualifiers first
      for (int k = 0; k < 5; k++) begin
         for (int s = 0; s < 2; s++) begin
            e    = 32'h1 << (((s && k == 1) ? TIS_MATCH_B_POS : pos[k]) + TIS_SUB_B_SHIFT * s);
            good = (k < 2) ? (s ? TIS_MODE_ONESHOT : TIS_MODE_PERIODIC) :
                   ((k < 4) ? TIS_MODE_CAPTURE : TIS_MODE_OFF);
            bad  = (k < 2) ? TIS_MODE_CAPTURE : TIS_MODE_PERIODIC;
            if (k < 4) begin
               pulse(k, s, bad, 2'b11);
               bus(1'b0, TIS_RAW_OFFSET, 32'h0, 4'hf, q);
               `CHK("raw wrong mode", 32'h0, q)
            end
            if (k == 1) begin
               pulse(k, s, good, 2'b00);
               bus(1'b0, TIS_RAW_OFFSET, 32'h0, 4'hf, q);
               `CHK("raw match disabled", 32'h0, q)
            end
            pulse(k, s, good, 2'b11);
            bus(1'b0, TIS_RAW_OFFSET, 32'h0, 4'hf, q);
            `CHK("raw set", e, q)
            bus(1'b0, TIS_MASKED_OFFSET, 32'h0, 4'hf, q);
            `CHK("masked set", e, q)
            `CHK("irq high", 1'b1, irq)
            bus(1'b1, TIS_CLEAR_OFFSET, e, 4'hf, q);
            bus(1'b0, TIS_RAW_OFFSET, 32'h0, 4'hf, q);
            `CHK("raw cleared", 32'h0, q)
            bus(1'b0, TIS_MASKED_OFFSET, 32'h0, 4'hf, q);
            `CHK("masked cleared", 32'h0, q)
            `CHK("irq low", 1'b0, irq)
         end
      end
      // Byte lane write leaves subtimer A masked
      bus(1'b1, TIS_MASK_OFFSET, 32'h0, 4'hf, q);
      bus(1'b1, TIS_MASK_OFFSET, 32'hffff_ffff, 4'h2, q);
      bus(1'b0, TIS_MASK_OFFSET, 32'h0, 4'hf, q);
      `CHK("mask lanes", 32'h0000_2f00, q)
      pulse(0, 0, TIS_MODE_PERIODIC, 2'b00);
      bus(1'b0, TIS_MASKED_OFFSET, 32'h0, 4'hf, q);
      `CHK("masked suppressed", 32'h0, q)
      `CHK("irq masked", 1'b0, irq)
      pulse(0, 1, TIS_MODE_ONESHOT, 2'b00);
      pulse(4, 1, TIS_MODE_OFF, 2'b00);
      bus(1'b0, TIS_MASKED_OFFSET, 32'h0, 4'hf, q);
      `CHK("masked B", 32'h0000_2100, q)
      // Zero bits of a clear leave flags alone
      bus(1'b1, TIS_CLEAR_OFFSET, 32'h0000_0100, 4'hf, q);
      bus(1'b0, TIS_RAW_OFFSET, 32'h0, 4'hf, q);
      `CHK("partial clear", 32'h0000_2001, q)
      // Status registers ignore writes, reserved and unmapped read zero
      bus(1'b1, TIS_RAW_OFFSET, 32'hffff_ffff, 4'hf, q);
      bus(1'b1, TIS_MASKED_OFFSET, 32'h0, 4'hf, q);
      bus(1'b0, TIS_RAW_OFFSET, 32'h0, 4'hf, q);
      `CHK("raw ignores write", 32'h0000_2001, q)
      bus(1'b0, TIS_MASKED_OFFSET, 32'h0, 4'hf, q);
      `CHK("masked ignores write", 32'h0000_2000, q)
      bus(1'b0, 8'h40, 32'h0, 4'hf, q);
      `CHK("unmapped read", 32'h0, q)
      bus(1'b0, TIS_CLEAR_OFFSET, 32'h0, 4'hf, q);
      `CHK("clear reads zero", 32'h0, q)
      bus(1'b1, TIS_CLEAR_OFFSET, 32'h0000_2001, 4'hf, q);
      bus(1'b0, TIS_RAW_OFFSET, 32'h0, 4'hf, q);
      `CHK("all cleared", 32'h0, q)
      `CHK("irq idle", 1'b0, irq)
      give_verdict();
   end
endmodule
